// File: hdl/eac_top.sv
// Energy accumulator input selection and configuration
//
// Summary of operation
// - Bits 5:4 select wiring configuration, reset 00, steering accumulator inputs.
// - Reactive current input is each phase current shifted by minus ninety degrees, except Phase B under select 01, which uses its unshifted current.
// - Select 00 uses each phase's own voltage and current.
// - Select 01 derives Phase B voltage as A minus C.
// - Select 10 derives Phase B voltage as minus A minus C.
// - Select 11 derives Phase B voltage as minus A.
// - Active is V times I, reactive V times shifted I, apparent rms product.
// - Bit 6 picks total or fundamental active power for reversal flags 6..8.
// - Bit 7 picks total or fundamental reactive power for flags 10..12.
// - Variants lacking fundamental power hold both source bits at zero.
// - Line-cycle bit 0 puts watt-hour accumulators in line-cycle mode.
// - Line-cycle bit 1 does the same for var-hour; zero without reactive.
// - Line-cycle bit 2 does the same for VA-hour accumulators.
// - Bits 3..5, reset one, add Phase A, B, C zero crossings.
// - Several selected phases each advance the count, shortening the period.
// - Bit 6, reset one, makes energy reads clear the accumulator.
// - Bit 7 is reserved and affects nothing.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module eac_top
  import eac_pkg::*;
#(
  parameter int  SW       = 24,
  parameter int  RW       = 24,
  parameter bit  HAS_FUND = 1'b1,
  parameter bit  HAS_REACT = 1'b1
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Register port
  input  wire logic [15:0]         addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [7:0]          rdata_o,
  // Per-phase samples, one sample period per strobe
  input  wire logic                sample_i,
  input  wire logic signed [SW-1:0] va_i,
  input  wire logic signed [SW-1:0] vb_i,
  input  wire logic signed [SW-1:0] vc_i,
  input  wire logic signed [SW-1:0] ia_i,
  input  wire logic signed [SW-1:0] ib_i,
  input  wire logic signed [SW-1:0] ic_i,
  input  wire logic signed [SW-1:0] ia_q_i,
  input  wire logic signed [SW-1:0] ib_q_i,
  input  wire logic signed [SW-1:0] ic_q_i,
  input  wire logic [RW-1:0]       vrms_a_i,
  input  wire logic [RW-1:0]       vrms_b_i,
  input  wire logic [RW-1:0]       vrms_c_i,
  input  wire logic [RW-1:0]       vrms_ac_i,
  input  wire logic [RW-1:0]       irms_a_i,
  input  wire logic [RW-1:0]       irms_b_i,
  input  wire logic [RW-1:0]       irms_c_i,
  // Power sign inputs, bit per phase A..C
  input  wire logic [2:0]          act_neg_total_i,
  input  wire logic [2:0]          act_neg_fund_i,
  input  wire logic [2:0]          react_neg_total_i,
  input  wire logic [2:0]          react_neg_fund_i,
  // Zero-crossing events per phase
  input  wire logic [2:0]          zx_i,
  // Energy accumulator read events, one bit per accumulator
  input  wire logic [14:0]         energy_rd_i,
  // Selected accumulator inputs
  output logic                     sample_o,
  output logic signed [SW-1:0]     act_v_o [3],
  output logic signed [SW-1:0]     act_i_o [3],
  output logic signed [SW-1:0]     react_v_o [3],
  output logic signed [SW-1:0]     react_i_o [3],
  output logic [RW-1:0]            app_v_o [3],
  output logic [RW-1:0]            app_i_o [3],
  output logic [RW-1:0]            phase_b_voltage_rms_o,
  // Mode and event outputs
  output logic                     active_line_cycle_enable_o,
  output logic                     reactive_line_cycle_enable_o,
  output logic                     apparent_line_cycle_enable_o,
  output logic [1:0]               zx_count_o,
  output logic [14:0]              energy_clear_o,
  output logic [5:0]               reversal_flags_o
);

  // ==========================================================
  // Parameter checks
  if (SW < 2 || RW < 1) begin : g_bad_width
    $error("eac_top: sample widths too small");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]          acc_cfg;
    logic [7:0]          lcyc_cfg;
    logic [7:0]          rdata;
    logic                smp;
    logic [2:0][SW-1:0]  av;
    logic [2:0][SW-1:0]  ai;
    logic [2:0][SW-1:0]  rv;
    logic [2:0][SW-1:0]  ri;
    logic [2:0][RW-1:0]  pv;
    logic [2:0][RW-1:0]  pi;
    logic [RW-1:0]       brms;
    logic [1:0]          zxc;
    logic [14:0]         clr;
    logic [5:0]          rev;
  } eac_state_t;

  eac_state_t st;
  eac_state_t next_st;

  logic [1:0]    wire_sel;
  logic signed [SW-1:0] vb_sel;

  // Phase B voltage by wiring select
  function automatic logic signed [SW-1:0] eac_phase_b(
    input logic [1:0]            sel,
    input logic signed [SW-1:0]  a,
    input logic signed [SW-1:0]  b,
    input logic signed [SW-1:0]  c
  );
    case (sel)
      WIRE_WYE3:   eac_phase_b = b;
      WIRE_DELTA3: eac_phase_b = SW'(a - c);
      WIRE_WYE2:   eac_phase_b = SW'(-a - c);
      WIRE_DELTA4: eac_phase_b = SW'(-a);
      default:     eac_phase_b = b;
    endcase
  endfunction : eac_phase_b

  // Count of set bits
  function automatic logic [1:0] eac_pop3(input logic [2:0] v);
    eac_pop3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction : eac_pop3

  assign wire_sel = st.acc_cfg[WIRE_SEL_LSB +: 2];
  assign vb_sel   = eac_phase_b(wire_sel, va_i, vb_i, vc_i);

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // Register writes
    if (wr_i) begin
      if (addr_i == ACC_CFG_ADDR) begin
        next_st.acc_cfg = wdata_i;
        if (!HAS_FUND) begin
          next_st.acc_cfg[ACT_REV_SRC]   = 1'b0;
          next_st.acc_cfg[REACT_REV_SRC] = 1'b0;
        end
      end else if (addr_i == LCYC_CFG_ADDR) begin
        next_st.lcyc_cfg = wdata_i;
        if (!HAS_REACT) begin
          next_st.lcyc_cfg[REACT_LC_EN] = 1'b0;
        end
      end
    end
    // Register reads
    if (rd_i) begin
      case (addr_i)
        ACC_CFG_ADDR:    next_st.rdata = st.acc_cfg;
        LCYC_CFG_ADDR:   next_st.rdata = st.lcyc_cfg;
        REV_STATUS_ADDR: next_st.rdata = {2'h0, st.rev};
        default:         next_st.rdata = 8'h00;
      endcase
    end
    // Accumulator inputs, all taken from one sample strobe
    next_st.smp = sample_i;
    if (sample_i) begin
      next_st.av[0] = va_i;
      next_st.av[1] = vb_sel;
      next_st.av[2] = vc_i;
      next_st.ai[0] = ia_i;
      next_st.ai[1] = ib_i;
      next_st.ai[2] = ic_i;
      next_st.rv    = next_st.av;
      next_st.ri[0] = ia_q_i;
      next_st.ri[1] = (wire_sel == WIRE_DELTA3) ? ib_i : ib_q_i;
      next_st.ri[2] = ic_q_i;
      next_st.pv[0] = vrms_a_i;
      next_st.pv[1] = (wire_sel == WIRE_DELTA3) ? vrms_ac_i : vrms_b_i;
      next_st.pv[2] = vrms_c_i;
      next_st.pi[0] = irms_a_i;
      next_st.pi[1] = irms_b_i;
      next_st.pi[2] = irms_c_i;
      next_st.brms  = (wire_sel == WIRE_DELTA3) ? vrms_ac_i : vrms_b_i;
    end
    // Reversal flag source selection
    next_st.rev[2:0] = st.acc_cfg[ACT_REV_SRC] ? act_neg_fund_i : act_neg_total_i;
    next_st.rev[5:3] = st.acc_cfg[REACT_REV_SRC] ? react_neg_fund_i : react_neg_total_i;
    // Zero crossings from every selected phase advance the count
    next_st.zxc = eac_pop3(zx_i & st.lcyc_cfg[ZX_SEL_LSB +: 3]);
    // Clear on read
    next_st.clr = st.lcyc_cfg[CLR_ON_READ] ? energy_rd_i : 15'h0000;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st          <= '0;
      st.acc_cfg  <= ACC_CFG_RESET;
      st.lcyc_cfg <= LCYC_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o                      = st.rdata;
  assign sample_o                     = st.smp;
  assign phase_b_voltage_rms_o        = st.brms;
  assign active_line_cycle_enable_o   = st.lcyc_cfg[ACT_LC_EN];
  assign reactive_line_cycle_enable_o = st.lcyc_cfg[REACT_LC_EN];
  assign apparent_line_cycle_enable_o = st.lcyc_cfg[APP_LC_EN];
  assign zx_count_o                   = st.zxc;
  assign energy_clear_o               = st.clr;
  assign reversal_flags_o             = st.rev;

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      act_v_o[k]   = st.av[k];
      act_i_o[k]   = st.ai[k];
      react_v_o[k] = st.rv[k];
      react_i_o[k] = st.ri[k];
      app_v_o[k]   = st.pv[k];
      app_i_o[k]   = st.pi[k];
    end
  end

endmodule : eac_top

// File: common/eac_pkg.sv
// Package for the energy accumulator configuration block
package eac_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] ACC_CFG_ADDR    = 16'hE701;
  localparam logic [15:0] LCYC_CFG_ADDR   = 16'hE702;
  localparam logic [15:0] REV_STATUS_ADDR = 16'hE703;
  // ==========================================================
  // Accumulation config fields
  localparam int ACC_MODE_LSB   = 0;
  localparam int WIRE_SEL_LSB   = 4;
  localparam int ACT_REV_SRC    = 6;
  localparam int REACT_REV_SRC  = 7;
  localparam logic [7:0] ACC_CFG_RESET  = 8'h00;
  // ==========================================================
  // Line-cycle config fields
  localparam int ACT_LC_EN      = 0;
  localparam int REACT_LC_EN    = 1;
  localparam int APP_LC_EN      = 2;
  localparam int ZX_SEL_LSB     = 3;
  localparam int CLR_ON_READ    = 6;
  localparam logic [7:0] LCYC_CFG_RESET = 8'h78;
  // ==========================================================
  // Status bit positions of reversal flags
  localparam int ACT_REV_FLAG_LSB   = 6;
  localparam int REACT_REV_FLAG_LSB = 10;
  // ==========================================================
  // Wiring configurations
  localparam logic [1:0] WIRE_WYE3  = 2'h0;
  localparam logic [1:0] WIRE_DELTA3 = 2'h1;
  localparam logic [1:0] WIRE_WYE2  = 2'h2;
  localparam logic [1:0] WIRE_DELTA4 = 2'h3;
endpackage : eac_pkg

// File: verif/eac_top_assertions.sv
// Assertion checker for the energy accumulator configuration block
`timescale 1ns/1ps
module eac_top_assertions
  import eac_pkg::*;
#(
  parameter int SW = 24,
  parameter int RW = 24,
  parameter bit HAS_FUND = 1'b1,
  parameter bit HAS_REACT = 1'b1
) (
  // Clock, reset and register port
  input wire logic                   clk_i, rst_i, wr_i, sample_i, sample_o,
  input wire logic [15:0]            addr_i,
  input wire logic [7:0]             wdata_i,
  // Samples and events
  input wire logic signed [SW-1:0]   va_i, vb_i, vc_i, ia_q_i, act_v_o [3], react_i_o [3],
  input wire logic [RW-1:0]          vrms_b_i, vrms_ac_i, phase_b_voltage_rms_o,
  input wire logic [2:0]             act_neg_total_i, act_neg_fund_i, react_neg_total_i, react_neg_fund_i, zx_i,
  input wire logic [14:0]            energy_rd_i, energy_clear_o,
  // Mode outputs
  input wire logic                   active_line_cycle_enable_o, reactive_line_cycle_enable_o,
  input wire logic                   apparent_line_cycle_enable_o,
  input wire logic [1:0]             zx_count_o,
  input wire logic [5:0]             reversal_flags_o
);
  // ==========================================================
  // Shadow configuration
  logic [7:0]           acc, lc;
  logic signed [SW-1:0] vb_exp;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= ACC_CFG_RESET;
      lc <= LCYC_CFG_RESET;
    end else if (wr_i && addr_i == ACC_CFG_ADDR) begin
      acc <= wdata_i & (HAS_FUND ? 8'hFF : 8'h3F);
    end else if (wr_i && addr_i == LCYC_CFG_ADDR) begin
      lc <= wdata_i & (HAS_REACT ? 8'hFF : 8'hFD);
    end
  end
  always_comb begin
    case (acc[5:4])
      WIRE_WYE3:   vb_exp = vb_i;
      WIRE_DELTA3: vb_exp = va_i - vc_i;
      WIRE_WYE2:   vb_exp = -va_i - vc_i;
      default:     vb_exp = -va_i;
    endcase
  end
  // ==========================================================
  // Properties
  act_pass_a: assert property (sample_i |=> act_v_o[0] == $past(va_i) && react_i_o[0] == $past(ia_q_i))
    else $error("phase A inputs not passed");
  wire_b_a: assert property (sample_i && acc == $past(acc) |=> sample_o && act_v_o[1] == $past(vb_exp))
    else $error("phase B voltage wrong");
  rms_b_a: assert property (sample_i && acc == $past(acc) |=> phase_b_voltage_rms_o ==
    ($past(acc[5:4]) == WIRE_DELTA3 ? $past(vrms_ac_i) : $past(vrms_b_i)))
    else $error("phase B rms wrong");
  rev_act_a: assert property (acc == $past(acc) |=> reversal_flags_o[2:0] ==
    ($past(acc[6]) ? $past(act_neg_fund_i) : $past(act_neg_total_i)))
    else $error("active reversal flags wrong");
  rev_react_a: assert property (acc == $past(acc) |=> reversal_flags_o[5:3] ==
    ($past(acc[7]) ? $past(react_neg_fund_i) : $past(react_neg_total_i)))
    else $error("reactive reversal flags wrong");
  lc_mode_a: assert property (lc == $past(lc) && lc == $past(lc, 2) |-> {apparent_line_cycle_enable_o,
    reactive_line_cycle_enable_o, active_line_cycle_enable_o} == lc[2:0])
    else $error("line-cycle enables wrong");
  zx_cnt_a: assert property (lc == $past(lc) |=> zx_count_o == $countones($past(zx_i) & $past(lc[5:3])))
    else $error("zero-cross count wrong");
  clr_read_a: assert property (lc == $past(lc) |=> energy_clear_o == ($past(energy_rd_i) & {15{$past(lc[6])}}))
    else $error("clear on read wrong");
endmodule : eac_top_assertions
bind eac_top eac_top_assertions #(.SW(SW), .RW(RW), .HAS_FUND(HAS_FUND), .HAS_REACT(HAS_REACT)) u_eac_chk (.*);

// File: verif/eac_top_tb_top.sv
// Testbench for the energy accumulator configuration block
`timescale 1ns/1ps
module eac_top_tb_top
  import eac_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sample_i = 0, sample_o;
  logic [15:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o;
  logic signed [23:0] va_i = 0, vb_i = 0, vc_i = 0, ia_i = 1, ib_i = 2, ic_i = 3;
  logic signed [23:0] ia_q_i = 0, ib_q_i = 4, ic_q_i = 5, act_v_o [3], act_i_o [3], react_v_o [3], react_i_o [3];
  logic [23:0] vrms_a_i = 1, vrms_b_i = 2, vrms_c_i = 3, vrms_ac_i = 4, irms_a_i = 5, irms_b_i = 6, irms_c_i = 7;
  logic [23:0] app_v_o [3], app_i_o [3], phase_b_voltage_rms_o;
  logic [23:0] vb_tab [4] = '{24'h000007, 24'h000046, 24'hFFFF7E, 24'hFFFF9C};
  logic [2:0] act_neg_total_i = 0, act_neg_fund_i = 0, react_neg_total_i = 0, react_neg_fund_i = 0, zx_i = 0;
  logic [14:0] energy_rd_i = 0, energy_clear_o;
  logic active_line_cycle_enable_o, reactive_line_cycle_enable_o, apparent_line_cycle_enable_o;
  logic [1:0] zx_count_o;
  logic [5:0] reversal_flags_o;
  int error_cnt = 0, num_checks = 0;
  eac_top u_eac_top (.*);
  initial forever #10 clk_i = ~clk_i;
  // ==========================================================
  // Tasks
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd
  task automatic pulse(input logic [2:0] z, input logic [1:0] n, input logic [14:0] c);
    @(posedge clk_i);
    zx_i <= z;
    energy_rd_i <= 15'h2A5A;
    @(posedge clk_i);
    zx_i <= 3'h0;
    energy_rd_i <= 15'h0;
    #1 chk(zx_count_o, n);
    chk(energy_clear_o, c);
  endtask : pulse
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ==========================================================
  // Sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    act_neg_total_i <= 3'h5;
    act_neg_fund_i <= 3'h2;
    react_neg_total_i <= 3'h3;
    react_neg_fund_i <= 3'h4;
    rd(ACC_CFG_ADDR, 8'h00);
    rd(LCYC_CFG_ADDR, 8'h78);
    rd(16'hE7FF, 8'h00);
    pulse(3'h7, 2'h3, 15'h2A5A);
    wr(LCYC_CFG_ADDR, 8'h87);
    rd(LCYC_CFG_ADDR, 8'h87);
    chk({apparent_line_cycle_enable_o, reactive_line_cycle_enable_o, active_line_cycle_enable_o}, 3'h7);
    pulse(3'h7, 2'h0, 15'h0);
    wr(LCYC_CFG_ADDR, 8'h28);
    pulse(3'h7, 2'h2, 15'h0);
    for (int s = 0; s < 4; s++) begin
      wr(ACC_CFG_ADDR, 8'(s << 4));
      @(posedge clk_i);
      sample_i <= 1'b1;
      va_i <= 24'h64;
      vb_i <= 24'h7;
      vc_i <= 24'h1E;
      ia_q_i <= 24'h9;
      @(posedge clk_i);
      sample_i <= 1'b0;
      #1 chk(sample_o, 1'b1);
      chk(act_v_o[1], vb_tab[s]);
      chk(act_v_o[0] ^ act_v_o[2] ^ react_i_o[0], 24'h64 ^ 24'h1E ^ 24'h9);
      chk(phase_b_voltage_rms_o, s == 1 ? 24'h4 : 24'h2);
      chk(app_v_o[1], s == 1 ? 24'h4 : 24'h2);
      chk(app_i_o[1], 24'h6);
      chk(act_i_o[1], 24'h2);
      chk(react_v_o[1], vb_tab[s]);
      chk(react_i_o[1], s == 1 ? 24'h2 : 24'h4);
    end
    for (int r = 0; r < 2; r++) begin
      wr(ACC_CFG_ADDR, r ? 8'hC0 : 8'h00);
      chk(reversal_flags_o, r ? 24'h22 : 24'h1D);
    end
    rd(REV_STATUS_ADDR, 8'h22);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
endmodule : eac_top_tb_top
